/* logic/flash_erase_pkg.sv */
// Command codes, addresses and timing constants for the flash erase host controller
package flash_erase_pkg;
    localparam logic [15:0] unlock1_data_c   = 16'h00aa;  // First unlock word
    localparam logic [15:0] unlock2_data_c   = 16'h0055;  // Second unlock word
    localparam logic [15:0] setup_data_c     = 16'h0080;  // Erase setup word
    localparam logic [15:0] sector_data_c    = 16'h0030;  // Sector erase and resume word
    localparam logic [15:0] chip_data_c      = 16'h0010;  // Chip erase word
    localparam logic [15:0] suspend_data_c   = 16'h00b0;  // Erase suspend word
    localparam logic [15:0] erased_data_c    = 16'hffff;  // Value of an erased word
    localparam logic [25:0] unlock1_addr_c   = 26'h0000555;  // Word address of cycles 1, 3, 4, and of cycle 6 of chip erase
    localparam logic [25:0] unlock2_addr_c   = 26'h00002aa;  // Word address of cycles 2, 5
    // Status bit positions on the data lines
    localparam int data_polling_pos_c = 7;  // Low while erasing, high when done
    localparam int toggle_pos_c       = 6;  // Toggles on each read while busy
    localparam int erase_timer_pos_c  = 3;  // High once the accept window closed
    localparam int alt_toggle_pos_c   = 2;  // Toggles in erasing or suspended sector
    // Timing in ns, and cycles at 250 MHz
    localparam int clk_period_ns_c    = 4;
    localparam int accept_window_ns_c = 50000;  // Sector accept window
    localparam int accept_gap_ns_c    = 40000;  // Our spacing margin, below the window
    localparam int suspend_max_ns_c   = 20000;  // Longest halt time after suspend
    localparam int accept_gap_cyc_c   = accept_gap_ns_c / clk_period_ns_c;
    localparam int suspend_max_cyc_c  = (suspend_max_ns_c + clk_period_ns_c - 1) / clk_period_ns_c;
    // Bus cycle timing in clock cycles
    localparam int we_low_cyc_c   = 4;  // Write strobe low time
    localparam int we_high_cyc_c  = 4;  // Write strobe high time
    localparam int rd_cyc_c       = 6;  // Read access time
    // Operations from the user
    typedef enum logic [2:0] {
        op_sector_erase, op_add_sector, op_chip_erase, op_suspend, op_resume, op_read, op_write
    } op_t;
endpackage : flash_erase_pkg

/* logic/flash_bus_cycle.sv */
// One asynchronous flash bus cycle, write or read, timed in clock cycles
module flash_bus_cycle #(
    parameter int AW = 26,  // Word address width
    parameter int DW = 16   // Data width
) (
    input  wire logic          sys_clk_in,     // System clock
    input  wire logic          rst_n_in,       // Asynchronous reset, active low
    input  wire logic          start_in,       // Start a cycle, taken when idle
    input  wire logic          write_in,       // High for write, low for read
    input  wire logic [AW-1:0] addr_in,        // Word address
    input  wire logic [DW-1:0] wdata_in,       // Write data
    input  wire logic [DW-1:0] dq_in,          // Data lines from the device
    output logic               busy_out,       // Cycle running
    output logic               done_out,       // One-cycle pulse at cycle end
    output logic [DW-1:0]      rdata_out,      // Read data, registered
    output logic [AW-1:0]      addr_out,       // Address pins
    output logic [DW-1:0]      dq_out,         // Data pins driven value
    output logic               dq_oe_out,      // Data pins enable, high drives
    output logic               we_n_out,       // Write strobe, active low
    output logic               oe_n_out,       // Output enable, active low
    output logic               ce_n_out        // Chip enable, active low
);
    localparam int CW = 4;
    localparam logic [CW-1:0] wlow_c  = CW'(flash_erase_pkg::we_low_cyc_c - 1);
    localparam logic [CW-1:0] whigh_c = CW'(flash_erase_pkg::we_high_cyc_c - 1);
    localparam logic [CW-1:0] rd_c    = CW'(flash_erase_pkg::rd_cyc_c - 1);

    typedef enum logic [1:0] {ph_idle, ph_strobe, ph_hold} phase_t;
    phase_t        phase_q;  // Bus phase
    logic [CW-1:0] cnt_q;    // Phase timer
    logic          wr_q;     // Current cycle is a write

    // Sequence the pins; the rising write strobe at end of strobe phase latches data
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            phase_q   <= ph_idle;
            cnt_q     <= '0;
            wr_q      <= 1'b0;
            busy_out  <= 1'b0;
            done_out  <= 1'b0;
            rdata_out <= '0;
            addr_out  <= '0;
            dq_out    <= '0;
            dq_oe_out <= 1'b0;
            we_n_out  <= 1'b1;
            oe_n_out  <= 1'b1;
            ce_n_out  <= 1'b1;
        end else begin
            done_out <= 1'b0;
            case (phase_q)
                ph_idle: begin
                    if (start_in) begin
                        phase_q   <= ph_strobe;
                        wr_q      <= write_in;
                        busy_out  <= 1'b1;
                        addr_out  <= addr_in;
                        dq_out    <= wdata_in;
                        dq_oe_out <= write_in;
                        ce_n_out  <= 1'b0;
                        we_n_out  <= !write_in;
                        oe_n_out  <= write_in;
                        cnt_q     <= write_in ? wlow_c : rd_c;
                    end
                end
                ph_strobe: begin
                    if (cnt_q != '0) begin
                        cnt_q <= cnt_q - 1'b1;
                    end else begin
                        // Write strobe rises here; read data is sampled here
                        if (!wr_q) begin
                            rdata_out <= dq_in;
                        end
                        we_n_out <= 1'b1;
                        oe_n_out <= 1'b1;
                        phase_q  <= ph_hold;
                        cnt_q    <= whigh_c;
                    end
                end
                ph_hold: begin
                    // Data held past the strobe edge, then bus released
                    if (cnt_q != '0) begin
                        cnt_q <= cnt_q - 1'b1;
                    end else begin
                        dq_oe_out <= 1'b0;
                        ce_n_out  <= 1'b1;
                        busy_out  <= 1'b0;
                        done_out  <= 1'b1;
                        phase_q   <= ph_idle;
                    end
                end
                default: begin
                    phase_q <= ph_idle;
                end
            endcase
        end
    end
endmodule : flash_bus_cycle

/* logic/flash_erase_host.sv */
// Host controller issuing erase, suspend and resume sequences to a parallel flash
module flash_erase_host #(
    parameter int AW          = 26,                                   // Word address width
    parameter int DW          = 16,                                   // Data width
    parameter int GAP_CYC     = flash_erase_pkg::accept_gap_cyc_c,    // Extra sector spacing
    parameter int SUSPEND_CYC = flash_erase_pkg::suspend_max_cyc_c    // Wait after suspend
) (
    input  wire logic                   sys_clk_in,    // System clock, 250 MHz
    input  wire logic                   rst_n_in,      // Asynchronous reset, active low
    input  wire logic                   req_in,        // Operation request, taken when ready
    input  wire flash_erase_pkg::op_t   op_in,         // Requested operation
    input  wire logic [AW-1:0]          addr_in,       // Sector or word address
    input  wire logic [DW-1:0]          wdata_in,      // Write data for op_write
    output logic                        ready_out,     // Idle and able to take a request
    output logic                        done_out,      // One-cycle pulse at completion
    output logic                        error_out,     // Request refused, pulse with done
    output logic [DW-1:0]               rdata_out,     // Read data of op_read
    output logic                        erasing_out,   // Sector erase running
    output logic                        suspended_out, // Erase suspended
    output logic                        chip_busy_out, // Chip erase running
    input  wire logic [DW-1:0]          dq_in,         // Data lines from the device
    output logic [DW-1:0]               dq_out,        // Data lines driven value
    output logic                        dq_oe_out,     // Data lines enable, high drives
    output logic [AW-1:0]               addr_out,      // Address pins
    output logic                        we_n_out,      // Write strobe, active low
    output logic                        oe_n_out,      // Output enable, active low
    output logic                        ce_n_out,      // Chip enable, active low
    output logic                        flash_rst_n_out // Hardware reset to device, low
);
    typedef enum logic [2:0] {st_idle, st_seq, st_wait_bus, st_poll, st_halt, st_finish}
        state_t;
    typedef enum logic [1:0] {md_none, md_sector, md_chip, md_suspended} mode_t;

    state_t          state_q;     // Sequencer state
    mode_t           mode_q;      // What the device is doing, as we see it
    logic [2:0]      step_q;      // Cycle index in a multi-cycle sequence
    logic [2:0]      last_q;      // Index of final cycle
    flash_erase_pkg::op_t op_q;   // Operation under way
    logic [AW-1:0]   taddr_q;     // Target address
    logic [DW-1:0]   tdata_q;     // Write data of op_write
    logic [31:0]     timer_q;     // Spacing and halt timer
    logic            bus_start_q; // Pulse to the bus cycle engine
    logic            bus_wr_q;    // Cycle is a write
    logic [AW-1:0]   bus_addr_q;  // Cycle address
    logic [DW-1:0]   bus_data_q;  // Cycle data
    logic            bus_busy;    // Engine running
    logic            bus_done;    // Engine finished a cycle
    logic [DW-1:0]   bus_rdata;   // Engine read data
    logic            poll_ref_q;  // Previous toggle bit while polling
    logic            poll_first_q;// First poll read pending
    logic            refused_q;   // Request taken but not started

    flash_bus_cycle #(.AW(AW), .DW(DW)) u_bus (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .start_in   (bus_start_q),
        .write_in   (bus_wr_q),
        .addr_in    (bus_addr_q),
        .wdata_in   (bus_data_q),
        .dq_in      (dq_in),
        .busy_out   (bus_busy),
        .done_out   (bus_done),
        .rdata_out  (bus_rdata),
        .addr_out   (addr_out),
        .dq_out     (dq_out),
        .dq_oe_out  (dq_oe_out),
        .we_n_out   (we_n_out),
        .oe_n_out   (oe_n_out),
        .ce_n_out   (ce_n_out)
    );

    // Address and data of each cycle of the six-cycle erase sequences
    function automatic logic [AW+DW-1:0] seq_word(input logic [2:0] step,
                                                  input flash_erase_pkg::op_t op,
                                                  input logic [AW-1:0] tgt);
        logic [AW-1:0] a;
        logic [DW-1:0] d;
        a = AW'(flash_erase_pkg::unlock1_addr_c);
        d = DW'(flash_erase_pkg::unlock1_data_c);
        case (step)
            3'h1, 3'h4: begin
                a = AW'(flash_erase_pkg::unlock2_addr_c);
                d = DW'(flash_erase_pkg::unlock2_data_c);
            end
            3'h2: d = DW'(flash_erase_pkg::setup_data_c);
            3'h5: begin
                if (op == flash_erase_pkg::op_chip_erase) begin
                    d = DW'(flash_erase_pkg::chip_data_c);
                end else begin
                    a = tgt;
                    d = DW'(flash_erase_pkg::sector_data_c);
                end
            end
            default: ;
        endcase
        return {a, d};
    endfunction : seq_word

    // Command sequencer: one cycle per step, then wait or poll as the operation needs
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q      <= st_idle;
            mode_q       <= md_none;
            step_q       <= '0;
            last_q       <= '0;
            op_q         <= flash_erase_pkg::op_read;
            taddr_q      <= '0;
            tdata_q      <= '0;
            timer_q      <= '0;
            bus_start_q  <= 1'b0;
            bus_wr_q     <= 1'b0;
            bus_addr_q   <= '0;
            bus_data_q   <= '0;
            poll_ref_q   <= 1'b0;
            poll_first_q <= 1'b0;
            refused_q    <= 1'b0;
            ready_out    <= 1'b0;
            done_out     <= 1'b0;
            error_out    <= 1'b0;
            rdata_out    <= '0;
        end else begin
            bus_start_q <= 1'b0;
            done_out    <= 1'b0;
            error_out   <= 1'b0;
            if (timer_q != '0) begin
                timer_q <= timer_q - 1;
            end
            case (state_q)
                st_idle: begin
                    ready_out <= 1'b1;
                    if (req_in && ready_out) begin
                        ready_out <= 1'b0;
                        op_q      <= op_in;
                        taddr_q   <= addr_in;
                        tdata_q   <= wdata_in;
                        step_q    <= '0;
                        state_q   <= st_seq;
                        last_q    <= '0;
                        case (op_in)
                            flash_erase_pkg::op_sector_erase,
                            flash_erase_pkg::op_chip_erase: begin
                                // New erases only from plain read mode
                                if (mode_q != md_none) state_q <= st_finish;
                                last_q <= 3'h5;
                            end
                            flash_erase_pkg::op_add_sector: begin
                                // Only while our spacing timer keeps the window open
                                if (mode_q != md_sector || timer_q == '0) begin
                                    state_q <= st_finish;
                                end
                            end
                            flash_erase_pkg::op_suspend: begin
                                if (mode_q != md_sector) state_q <= st_finish;
                            end
                            flash_erase_pkg::op_resume: begin
                                if (mode_q != md_suspended) state_q <= st_finish;
                            end
                            default: begin
                                // Reads and writes: not while any erase is in charge
                                if (mode_q == md_sector || mode_q == md_chip) begin
                                    state_q <= st_finish;
                                end
                            end
                        endcase
                        // Assumed refused; cleared once the first bus cycle is set up
                        refused_q <= 1'b1;
                    end
                end
                st_seq: begin
                    refused_q   <= 1'b0;
                    bus_start_q <= 1'b1;
                    bus_wr_q    <= op_q != flash_erase_pkg::op_read;
                    case (op_q)
                        flash_erase_pkg::op_sector_erase,
                        flash_erase_pkg::op_chip_erase: begin
                            {bus_addr_q, bus_data_q} <= seq_word(step_q, op_q, taddr_q);
                        end
                        flash_erase_pkg::op_add_sector: begin
                            bus_addr_q <= taddr_q;
                            bus_data_q <= flash_erase_pkg::sector_data_c;
                        end
                        flash_erase_pkg::op_suspend: begin
                            bus_addr_q <= taddr_q;
                            bus_data_q <= flash_erase_pkg::suspend_data_c;
                        end
                        flash_erase_pkg::op_resume: begin
                            bus_addr_q <= taddr_q;
                            bus_data_q <= flash_erase_pkg::sector_data_c;
                        end
                        default: begin
                            // Suspended program or read of other sectors
                            bus_addr_q <= taddr_q;
                            bus_data_q <= tdata_q;
                        end
                    endcase
                    state_q <= st_wait_bus;
                end
                st_wait_bus: begin
                    if (bus_done) begin
                        if (step_q != last_q) begin
                            step_q  <= step_q + 3'h1;
                            state_q <= st_seq;
                        end else begin
                            // Final strobe has risen: the window runs from here
                            case (op_q)
                                flash_erase_pkg::op_sector_erase,
                                flash_erase_pkg::op_add_sector: begin
                                    mode_q  <= md_sector;
                                    timer_q <= 32'(GAP_CYC);
                                    state_q <= st_finish;
                                end
                                flash_erase_pkg::op_chip_erase: begin
                                    mode_q  <= md_chip;
                                    state_q <= st_finish;
                                end
                                flash_erase_pkg::op_suspend: begin
                                    timer_q <= 32'(SUSPEND_CYC);
                                    state_q <= st_halt;
                                end
                                flash_erase_pkg::op_resume: begin
                                    mode_q  <= md_sector;
                                    state_q <= st_finish;
                                end
                                flash_erase_pkg::op_read: begin
                                    rdata_out <= bus_rdata;
                                    state_q   <= st_finish;
                                end
                                default: begin
                                    // Program while suspended: poll to completion
                                    poll_first_q <= 1'b1;
                                    state_q      <= st_poll;
                                end
                            endcase
                        end
                    end
                end
                st_halt: begin
                    // Suspend takes effect within the longest halt time
                    if (timer_q == '0) begin
                        mode_q  <= md_suspended;
                        state_q <= st_finish;
                    end
                end
                st_poll: begin
                    // Two reads in a row with equal toggle bit mean done
                    if (!bus_busy && !bus_start_q) begin
                        bus_start_q <= 1'b1;
                        bus_wr_q    <= 1'b0;
                        bus_addr_q  <= taddr_q;
                    end
                    if (bus_done) begin
                        poll_first_q <= 1'b0;
                        poll_ref_q   <= bus_rdata[flash_erase_pkg::toggle_pos_c];
                        if (!poll_first_q &&
                            bus_rdata[flash_erase_pkg::toggle_pos_c] == poll_ref_q) begin
                            bus_start_q <= 1'b0;
                            state_q     <= st_finish;
                        end
                    end
                end
                st_finish: begin
                    done_out  <= 1'b1;
                    error_out <= refused_q;  // Refusal shown alongside done
                    state_q   <= st_idle;
                end
                default: begin
                    state_q <= st_idle;
                end
            endcase
        end
    end

    // Erase completion is not tracked: mode_q leaves chip mode only at reset, sector mode only at reset or suspend,
    // and op_read is refused in those modes; this block decodes mode_q into levels and releases the device reset.
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            erasing_out     <= 1'b0;
            suspended_out   <= 1'b0;
            chip_busy_out   <= 1'b0;
            flash_rst_n_out <= 1'b0;
        end else begin
            flash_rst_n_out <= 1'b1;
            erasing_out     <= mode_q == md_sector;
            suspended_out   <= mode_q == md_suspended;
            chip_busy_out   <= mode_q == md_chip;
        end
    end
endmodule : flash_erase_host

/* dv/flash_erase_host_chk.sv */
// Checker of the erase host's pin and handshake behaviour
module flash_erase_host_chk (
    input wire logic sys_clk_in, rst_n_in, req_in, ready_out, done_out, // Handshake
    input wire logic we_n_out, ce_n_out, dq_oe_out, flash_rst_n_out, // Flash strobes
    input wire logic chip_busy_out, suspended_out, // Mode levels
    input wire logic [15:0] dq_out, // Driven data
    input wire logic [25:0] addr_out // Address pins
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    // Strobe only with select and data driven
    a_strobe_selected: assert property (!we_n_out |-> !ce_n_out && dq_oe_out)
        else $error("strobe outside select");
    // Word and address held while the strobe is low
    a_write_held: assert property ($fell(we_n_out) |=> ($stable(dq_out) && $stable(addr_out))[*3])
        else $error("write word moved");
    a_dev_reset_off: assert property ($past(rst_n_in) |-> flash_rst_n_out)
        else $error("device reset low");
    // A chip erase may not be disturbed once running
    a_chip_quiet: assert property (chip_busy_out && $past(chip_busy_out, 9) |-> we_n_out)
        else $error("write during chip erase");
    a_modes_apart: assert property (!(suspended_out && chip_busy_out))
        else $error("suspended in chip erase");
    a_done_single: assert property (done_out |=> !done_out)
        else $error("done too long");
    a_take_clears: assert property (req_in && ready_out |=> !ready_out)
        else $error("ready after take");
endmodule : flash_erase_host_chk
bind flash_erase_host flash_erase_host_chk i_chk (.*);

/* dv/flash_model.sv */
// Behavioural flash device answering erase command sequences
module flash_model (
    input  wire logic        rst_n_in, we_n_in, ce_n_in, oe_n_in, // Device pins
    input  wire logic [25:0] addr_in,   // Word address
    input  wire logic [15:0] dq_in,     // Data written by the host
    output logic      [15:0] dq_out     // Data returned to the host
);
    timeunit 1ns; timeprecision 1ps;
    logic [15:0] ld [5] = '{16'h00aa, 16'h0055, 16'h0080, 16'h00aa, 16'h0055}; // Lead words
    logic [11:0] la [5] = '{12'h555, 12'h2aa, 12'h555, 12'h555, 12'h2aa}; // Lead addresses
    int step = 0, writes = 0; // Sequence position, strobe count
    logic [1:0] mode = 0; // 0 read, 1 sector, 2 chip, 3 suspended
    logic tog = 0; // Flips on each read
    always @(posedge oe_n_in) tog <= ~tog;
    // Commands count at the strobe's rising edge
    always @(posedge we_n_in or negedge rst_n_in) begin
        if (!rst_n_in) begin mode = 0; step = 0; end
        else if (!ce_n_in) begin
            writes++;
            if (mode == 1) mode = dq_in == 16'h00b0 ? 2'd3 : dq_in == 16'h0030 ? 2'd1 : 2'd0;
            else if (mode == 3) mode = dq_in == 16'h0030 ? 2'd1 : 2'd3;
            else if (mode == 0 && step == 5) begin
                mode = dq_in == 16'h0030 ? 2'd1 : (dq_in == 16'h0010 && addr_in == 26'h555) ? 2'd2 : 2'd0;
                step = 0;
            end else if (mode == 0) step = (dq_in == ld[step] && addr_in == 26'(la[step])) ? step + 1 : 0;
        end // Chip mode ignores all writes
    end
    // Erased array reads all ones; busy shows status; released lines return 5a5a flipped with tog
    assign dq_out = (oe_n_in | ce_n_in) ? 16'h5a5a ^ {16{tog}} : (mode == 0) ? 16'hffff
        : {8'h00, 1'b0, tog, 2'b00, mode != 1, tog, 2'b00};
endmodule : flash_model

/* dv/testbench.sv */
// Self-checking bench for the flash erase host controller
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
    timeunit 1ns; timeprecision 1ps;
    logic sys_clk_in = 0, rst_n_in = 0, req_in = 0, ready_out, done_out, error_out;
    flash_erase_pkg::op_t op_in = flash_erase_pkg::op_read; // Requested operation
    logic [25:0] addr_in = '0, addr_out;
    logic [15:0] wdata_in = '0, rdata_out, dq_in, dq_out;
    logic erasing_out, suspended_out, chip_busy_out, dq_oe_out, we_n_out, oe_n_out, ce_n_out;
    logic flash_rst_n_out;
    int mismatches = 0, checks_done = 0;
    always #2 sys_clk_in = ~sys_clk_in; // 250 MHz
    flash_erase_host #(.GAP_CYC(20), .SUSPEND_CYC(20)) i_flash_erase_host (.*);
    flash_model i_flash_model (.rst_n_in(flash_rst_n_out), .we_n_in(we_n_out), .ce_n_in(ce_n_out),
        .oe_n_in(oe_n_out), .addr_in(addr_out), .dq_in(dq_out), .dq_out(dq_in));
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : tally_and_finish
    task automatic do_reset;
        rst_n_in = 0;
        repeat (8) @(posedge sys_clk_in);
        #1 rst_n_in = 1;
    endtask : do_reset
    // One request held until taken, then a bounded wait for done
    task automatic run_op(input flash_erase_pkg::op_t op, input logic [25:0] a);
        int n = 0;
        op_in = op;
        addr_in = a;
        req_in = 1;
        // Ready is looked at off the edge, so the next edge is the one that takes
        while (ready_out !== 1'b1 && n < 99) begin @(posedge sys_clk_in); #1 n++; end
        @(posedge sys_clk_in);
        #1 req_in = 0;
        do begin @(posedge sys_clk_in); #1 n++; end while (done_out !== 1'b1 && n < 299);
        if (n >= 299) begin mismatches++; tally_and_finish(); end
    endtask : run_op
    task automatic t_sector; // Erase, extra sector, suspend, resume twice
        run_op(flash_erase_pkg::op_suspend, 26'h0);
        `CHK(error_out, 1'b1)
        run_op(flash_erase_pkg::op_add_sector, 26'h20000);
        `CHK(i_flash_model.writes, 0)
        run_op(flash_erase_pkg::op_sector_erase, 26'h10000);
        `CHK(i_flash_model.writes, 6)
        `CHK(error_out, 1'b0)
        run_op(flash_erase_pkg::op_add_sector, 26'h30000);
        `CHK(i_flash_model.mode, 2'd1)
        run_op(flash_erase_pkg::op_suspend, 26'h5);
        `CHK(suspended_out, 1'b1)
        run_op(flash_erase_pkg::op_resume, 26'h7);
        `CHK(erasing_out, 1'b1)
        run_op(flash_erase_pkg::op_resume, 26'h7);
        `CHK(i_flash_model.writes, 9)
        `CHK(i_flash_model.mode, 2'd1)
        $display("sector test ended");
    endtask : t_sector
    task automatic t_chip; // Reset mid-erase, read, chip erase ignores suspend
        do_reset();
        `CHK(i_flash_model.mode, 2'd0)
        run_op(flash_erase_pkg::op_read, 26'h100);
        `CHK(rdata_out, 16'hffff)
        run_op(flash_erase_pkg::op_chip_erase, 26'h0);
        run_op(flash_erase_pkg::op_suspend, 26'h0);
        `CHK(i_flash_model.mode, 2'd2)
        `CHK(i_flash_model.writes, 15)
        `CHK(chip_busy_out, 1'b1)
        $display("chip test ended");
    endtask : t_chip
    initial begin
        do_reset();
        t_sector();
        t_chip();
        tally_and_finish();
    end
endmodule : testbench
